// file: hw/pmic_control_register_bank.sv
// Power-management control bank with its two-wire serial slave
`timescale 1ns/1ps
`default_nettype none
// How it works
// R1: 0x02 and 0x11 read-only, rest writable
// R2: thermal D1 follows over-temperature
// R3: 0x07 D6-4 choose delay preset
// R4: preset code maps to four delays
// R5: D2/D1 force PWM for buck2/buck1
// R6: 0x07 D7 reads 0, D3 1, D0 resets 0
// R7: enable bits D6, D4, D2, D0 gate regulators
// R8: enables reset high, reserved D5 one
// R9: status shows each regulator valid flag
// R10: D7 both bucks, D6 both linregs valid
// R11: 0x20 D5/D1 pick target register
// R12: 0x20 D4/D0 hold or ramp
// R13: buck1 targets 0x23, 0x24, ramp 0x25
// R14: buck2 targets 0x29, 0x2A, ramp 0x2B
// R15: buck function, linreg voltages decoded
// R16: write is address, register, data byte
// R17: read: pointer write, repeated start
// R18: bytes MSB first, ninth clock acknowledges
// R19: reserved and unmapped bits ignore writes
module pmic_control_register_bank
  import pmic_regs_pkg::*;
#(
  parameter logic [6:0] DEVICE_ADDRESS = DEFAULT_DEVICE_ADDRESS,
  parameter logic [2:0] FACTORY_DELAY_PRESET = 3'h0,
  parameter logic FACTORY_BUCK_ONE_PWM = 1'h0,
  parameter logic FACTORY_BUCK_TWO_PWM = 1'h0,
  parameter logic [4:0] FACTORY_BUCK_ONE_TARGET = 5'h00,
  parameter logic [4:0] FACTORY_BUCK_TWO_TARGET = 5'h00,
  parameter logic [7:0] FACTORY_BUCK_FUNCTION = 8'h00,
  parameter logic [7:0] FACTORY_LINREG_ONE_VOLTAGE = 8'h00,
  parameter logic [7:0] FACTORY_LINREG_TWO_VOLTAGE = 8'h00
) (
  input wire logic mclk,
  input wire logic sys_rst,
  input wire logic scl_in,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe_n,
  input wire logic over_temperature,
  input wire logic buck_one_valid,
  input wire logic buck_two_valid,
  input wire logic linreg_one_valid,
  input wire logic linreg_two_valid,
  output logic [2:0] power_on_delay_preset,
  output logic [4:0] buck_one_delay,
  output logic [4:0] buck_two_delay,
  output logic [4:0] linreg_one_delay,
  output logic [4:0] linreg_two_delay,
  output logic buck_one_forced_pwm,
  output logic buck_two_forced_pwm,
  output logic external_clock_select,
  output logic buck_one_on,
  output logic buck_two_on,
  output logic linreg_one_on,
  output logic linreg_two_on,
  output logic buck_one_target_select,
  output logic buck_two_target_select,
  output logic buck_one_ramp_go,
  output logic buck_two_ramp_go,
  output logic [4:0] buck_one_target_a,
  output logic [4:0] buck_one_target_b,
  output logic [3:0] buck_one_ramp_rate,
  output logic [4:0] buck_two_target_a,
  output logic [4:0] buck_two_target_b,
  output logic [3:0] buck_two_ramp_rate,
  output logic [7:0] buck_function,
  output logic [7:0] linreg_one_voltage,
  output logic [7:0] linreg_two_voltage
);
  logic scl_rise;
  logic scl_fall;
  logic start_seen;
  logic stop_seen;

  link_state_t state_reg, state_next;
  logic [3:0] bit_cnt_reg, bit_cnt_next;
  logic [7:0] shift_reg, shift_next;
  logic [7:0] ptr_reg, ptr_next;
  logic rw_reg, rw_next;
  logic master_ack_reg, master_ack_next;
  logic drive_low_reg, drive_low_next;
  logic wr_stb;
  logic [7:0] rd_data;

  logic [2:0] preset_reg, preset_next;
  logic [19:0] delays_reg, delays_next;
  logic pwm1_reg, pwm1_next, pwm2_reg, pwm2_next;
  logic ext_clk_reg, ext_clk_next;
  logic [3:0] on_reg, on_next;
  logic sel1_reg, sel1_next, sel2_reg, sel2_next;
  logic go1_reg, go1_next, go2_reg, go2_next;
  logic [4:0] t1a_reg, t1a_next, t1b_reg, t1b_next;
  logic [4:0] t2a_reg, t2a_next, t2b_reg, t2b_next;
  logic [3:0] rr1_reg, rr1_next, rr2_reg, rr2_next;
  logic [7:0] bfunc_reg, bfunc_next;
  logic [7:0] lv1_reg, lv1_next, lv2_reg, lv2_next;
  logic hot_reg, hot_next;
  logic [3:0] valid_reg, valid_next;
  logic sda_out_reg;

  serial_line_events u_events (
    .mclk(mclk),
    .sys_rst(sys_rst),
    .scl_in(scl_in),
    .sda_in(sda_in),
    .scl_rise(scl_rise),
    .scl_fall(scl_fall),
    .start_seen(start_seen),
    .stop_seen(stop_seen)
  );

  // Read multiplexer; reserved bits show their fixed values
  always_comb begin
    rd_data = 8'h00; // [R19]
    unique case (ptr_reg)
      ADDR_THERMAL_FLAG_STATUS: rd_data[THERMAL_FLAG_BIT] = hot_reg; // [R2]
      ADDR_SYSTEM_CONTROL_ONE: begin
        rd_data[DELAY_PRESET_LSB +: 3] = preset_reg; // [R3]
        rd_data[SCR_RESERVED_ONE_BIT] = 1'h1; // [R6]
        rd_data[BUCK_TWO_PWM_BIT] = pwm2_reg;
        rd_data[BUCK_ONE_PWM_BIT] = pwm1_reg;
        rd_data[EXT_CLOCK_BIT] = ext_clk_reg;
      end
      ADDR_REGULATOR_ENABLE: begin
        rd_data[LINREG_TWO_ON_BIT] = on_reg[3];
        rd_data[ENABLE_RESERVED_ONE_BIT] = 1'h1; // [R8]
        rd_data[LINREG_ONE_ON_BIT] = on_reg[2];
        rd_data[BUCK_TWO_ON_BIT] = on_reg[1];
        rd_data[BUCK_ONE_ON_BIT] = on_reg[0];
      end
      ADDR_REGULATOR_VALID_STATUS: begin
        rd_data[ALL_BUCKS_VALID_BIT] = valid_reg[0] & valid_reg[1]; // [R10]
        rd_data[ALL_LINREGS_VALID_BIT] = valid_reg[2] & valid_reg[3]; // [R10]
        rd_data[LINREG_TWO_VALID_BIT] = valid_reg[3]; // [R9]
        rd_data[LINREG_ONE_VALID_BIT] = valid_reg[2]; // [R9]
        rd_data[BUCK_TWO_VALID_BIT] = valid_reg[1]; // [R9]
        rd_data[BUCK_ONE_VALID_BIT] = valid_reg[0]; // [R9]
      end
      ADDR_VOLTAGE_CHANGE_CONTROL: begin
        rd_data[BUCK_TWO_SELECT_BIT] = sel2_reg;
        rd_data[BUCK_TWO_GO_BIT] = go2_reg;
        rd_data[BUCK_ONE_SELECT_BIT] = sel1_reg;
        rd_data[BUCK_ONE_GO_BIT] = go1_reg;
      end
      ADDR_BUCK_ONE_TARGET_A: rd_data[4:0] = t1a_reg; // [R13]
      ADDR_BUCK_ONE_TARGET_B: rd_data[4:0] = t1b_reg; // [R13]
      ADDR_BUCK_ONE_RAMP_RATE: rd_data[6:0] = {RAMP_RESERVED_VALUE, rr1_reg}; // [R13]
      ADDR_BUCK_TWO_TARGET_A: rd_data[4:0] = t2a_reg; // [R14]
      ADDR_BUCK_TWO_TARGET_B: rd_data[4:0] = t2b_reg; // [R14]
      ADDR_BUCK_TWO_RAMP_RATE: rd_data[6:0] = {RAMP_RESERVED_VALUE, rr2_reg}; // [R14]
      ADDR_BUCK_FUNCTION: rd_data = bfunc_reg; // [R15]
      ADDR_LINREG_ONE_VOLTAGE: rd_data = lv1_reg; // [R15]
      ADDR_LINREG_TWO_VOLTAGE: rd_data = lv2_reg; // [R15]
      default: rd_data = 8'h00; // [R19]
    endcase
  end

  // Serial protocol sequencing
  always_comb begin
    state_next = state_reg;
    bit_cnt_next = bit_cnt_reg;
    shift_next = shift_reg;
    ptr_next = ptr_reg;
    rw_next = rw_reg;
    master_ack_next = master_ack_reg;
    drive_low_next = drive_low_reg;
    wr_stb = 1'h0;
    if (stop_seen) begin
      state_next = ST_IDLE;
      drive_low_next = 1'h0;
    end else if (start_seen) begin
      // Repeated start behaves exactly like a first start
      state_next = ST_ADDR; // [R17]
      bit_cnt_next = 4'h0;
      drive_low_next = 1'h0;
    end else begin
      unique case (state_reg)
        ST_IDLE: state_next = ST_IDLE;
        ST_ADDR, ST_REG, ST_WDATA: begin
          if (scl_rise && bit_cnt_reg != BITS_PER_BYTE) begin
            shift_next = {shift_reg[6:0], sda_in}; // [R18]
            bit_cnt_next = bit_cnt_reg + 4'h1;
          end else if (scl_fall && bit_cnt_reg == BITS_PER_BYTE) begin
            bit_cnt_next = 4'h0;
            drive_low_next = 1'h1; // [R18]
            if (state_reg == ST_ADDR) begin
              if (shift_reg[7:1] == DEVICE_ADDRESS) begin
                rw_next = shift_reg[0]; // [R16]
                state_next = ST_ADDR_ACK;
              end else begin
                drive_low_next = 1'h0;
                state_next = ST_IDLE;
              end
            end else if (state_reg == ST_REG) begin
              ptr_next = shift_reg; // [R16]
              state_next = ST_REG_ACK;
            end else begin
              wr_stb = 1'h1; // [R16]
              state_next = ST_WDATA_ACK;
            end
          end
        end
        ST_ADDR_ACK, ST_RDATA_ACK: begin
          if (scl_rise && state_reg == ST_RDATA_ACK) begin
            master_ack_next = ~sda_in;
          end
          if (scl_fall) begin
            drive_low_next = 1'h0;
            state_next = ST_REG;
            if (state_reg == ST_RDATA_ACK && !master_ack_reg) begin
              state_next = ST_IDLE;
            end else if (state_reg == ST_RDATA_ACK || rw_reg) begin
              state_next = ST_RDATA; // [R17]
              shift_next = rd_data;
              drive_low_next = ~rd_data[7]; // [R18]
              bit_cnt_next = 4'h1;
            end
          end
        end
        ST_REG_ACK, ST_WDATA_ACK: begin
          if (scl_fall) begin
            drive_low_next = 1'h0;
            state_next = ST_WDATA;
          end
        end
        ST_RDATA: begin
          if (scl_fall) begin
            if (bit_cnt_reg == BITS_PER_BYTE) begin
              drive_low_next = 1'h0; // [R18]
              bit_cnt_next = 4'h0;
              master_ack_next = 1'h0;
              state_next = ST_RDATA_ACK;
            end else begin
              drive_low_next = ~shift_reg[6];
              shift_next = {shift_reg[6:0], 1'h0};
              bit_cnt_next = bit_cnt_reg + 4'h1;
            end
          end
        end
      endcase
    end
  end

  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      state_reg <= ST_IDLE;
      bit_cnt_reg <= 4'h0;
      shift_reg <= 8'h00;
      ptr_reg <= 8'h00;
      rw_reg <= 1'h0;
      master_ack_reg <= 1'h0;
      drive_low_reg <= 1'h0;
      sda_out_reg <= 1'h0;
    end else begin
      state_reg <= state_next;
      bit_cnt_reg <= bit_cnt_next;
      shift_reg <= shift_next;
      ptr_reg <= ptr_next;
      rw_reg <= rw_next;
      master_ack_reg <= master_ack_next;
      drive_low_reg <= drive_low_next;
      sda_out_reg <= 1'h0;
    end
  end

  // Register writes; read-only and reserved bits ignore data
  always_comb begin
    preset_next = preset_reg;
    pwm1_next = pwm1_reg;
    pwm2_next = pwm2_reg;
    ext_clk_next = ext_clk_reg;
    on_next = on_reg;
    sel1_next = sel1_reg;
    sel2_next = sel2_reg;
    go1_next = go1_reg;
    go2_next = go2_reg;
    t1a_next = t1a_reg;
    t1b_next = t1b_reg;
    rr1_next = rr1_reg;
    t2a_next = t2a_reg;
    t2b_next = t2b_reg;
    rr2_next = rr2_reg;
    bfunc_next = bfunc_reg;
    lv1_next = lv1_reg;
    lv2_next = lv2_reg;
    hot_next = over_temperature; // [R2]
    valid_next = {linreg_two_valid, linreg_one_valid, buck_two_valid, buck_one_valid}; // [R9]
    if (wr_stb) begin
      unique case (ptr_reg)
        ADDR_SYSTEM_CONTROL_ONE: begin
          preset_next = shift_reg[DELAY_PRESET_LSB +: 3]; // [R3]
          pwm2_next = shift_reg[BUCK_TWO_PWM_BIT]; // [R5]
          pwm1_next = shift_reg[BUCK_ONE_PWM_BIT]; // [R5]
          ext_clk_next = shift_reg[EXT_CLOCK_BIT]; // [R6]
        end
        ADDR_REGULATOR_ENABLE: begin
          on_next = {shift_reg[LINREG_TWO_ON_BIT], shift_reg[LINREG_ONE_ON_BIT],
                     shift_reg[BUCK_TWO_ON_BIT], shift_reg[BUCK_ONE_ON_BIT]}; // [R7]
        end
        ADDR_VOLTAGE_CHANGE_CONTROL: begin
          sel2_next = shift_reg[BUCK_TWO_SELECT_BIT]; // [R11]
          go2_next = shift_reg[BUCK_TWO_GO_BIT]; // [R12]
          sel1_next = shift_reg[BUCK_ONE_SELECT_BIT]; // [R11]
          go1_next = shift_reg[BUCK_ONE_GO_BIT]; // [R12]
        end
        ADDR_BUCK_ONE_TARGET_A: t1a_next = shift_reg[4:0]; // [R13]
        ADDR_BUCK_ONE_TARGET_B: t1b_next = shift_reg[4:0]; // [R13]
        ADDR_BUCK_ONE_RAMP_RATE: rr1_next = shift_reg[3:0]; // [R13]
        ADDR_BUCK_TWO_TARGET_A: t2a_next = shift_reg[4:0]; // [R14]
        ADDR_BUCK_TWO_TARGET_B: t2b_next = shift_reg[4:0]; // [R14]
        ADDR_BUCK_TWO_RAMP_RATE: rr2_next = shift_reg[3:0]; // [R14]
        ADDR_BUCK_FUNCTION: bfunc_next = shift_reg; // [R15]
        ADDR_LINREG_ONE_VOLTAGE: lv1_next = shift_reg; // [R15]
        ADDR_LINREG_TWO_VOLTAGE: lv2_next = shift_reg; // [R15]
        default: preset_next = preset_reg; // [R1] [R19]
      endcase
    end
    delays_next = DELAY_TABLE[preset_next]; // [R4]
  end

  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      preset_reg <= FACTORY_DELAY_PRESET; // [R3]
      delays_reg <= DELAY_TABLE[FACTORY_DELAY_PRESET];
      pwm1_reg <= FACTORY_BUCK_ONE_PWM; // [R5]
      pwm2_reg <= FACTORY_BUCK_TWO_PWM; // [R5]
      ext_clk_reg <= RST_EXT_CLOCK; // [R6]
      on_reg <= {4{RST_REGULATOR_ON}}; // [R8]
      sel1_reg <= RST_VCC_BIT; // [R12]
      sel2_reg <= RST_VCC_BIT;
      go1_reg <= RST_VCC_BIT;
      go2_reg <= RST_VCC_BIT;
      t1a_reg <= FACTORY_BUCK_ONE_TARGET;
      t1b_reg <= FACTORY_BUCK_ONE_TARGET;
      rr1_reg <= RST_RAMP_RATE;
      t2a_reg <= FACTORY_BUCK_TWO_TARGET;
      t2b_reg <= FACTORY_BUCK_TWO_TARGET;
      rr2_reg <= RST_RAMP_RATE;
      bfunc_reg <= FACTORY_BUCK_FUNCTION;
      lv1_reg <= FACTORY_LINREG_ONE_VOLTAGE;
      lv2_reg <= FACTORY_LINREG_TWO_VOLTAGE;
      hot_reg <= RST_STATUS_BIT; // [R2]
      valid_reg <= {4{RST_STATUS_BIT}}; // [R10]
    end else begin
      preset_reg <= preset_next;
      delays_reg <= delays_next;
      pwm1_reg <= pwm1_next;
      pwm2_reg <= pwm2_next;
      ext_clk_reg <= ext_clk_next;
      on_reg <= on_next;
      sel1_reg <= sel1_next;
      sel2_reg <= sel2_next;
      go1_reg <= go1_next;
      go2_reg <= go2_next;
      t1a_reg <= t1a_next;
      t1b_reg <= t1b_next;
      rr1_reg <= rr1_next;
      t2a_reg <= t2a_next;
      t2b_reg <= t2b_next;
      rr2_reg <= rr2_next;
      bfunc_reg <= bfunc_next;
      lv1_reg <= lv1_next;
      lv2_reg <= lv2_next;
      hot_reg <= hot_next;
      valid_reg <= valid_next;
    end
  end

  always_comb begin
    sda_out = sda_out_reg;
    sda_oe_n = ~drive_low_reg; // [R18]
    power_on_delay_preset = preset_reg;
    {buck_one_delay, buck_two_delay, linreg_one_delay, linreg_two_delay} = delays_reg;
    buck_one_forced_pwm = pwm1_reg;
    buck_two_forced_pwm = pwm2_reg;
    external_clock_select = ext_clk_reg;
    {linreg_two_on, linreg_one_on, buck_two_on, buck_one_on} = on_reg;
    buck_one_target_select = sel1_reg;
    buck_two_target_select = sel2_reg;
    buck_one_ramp_go = go1_reg;
    buck_two_ramp_go = go2_reg;
    buck_one_target_a = t1a_reg;
    buck_one_target_b = t1b_reg;
    buck_one_ramp_rate = rr1_reg;
    buck_two_target_a = t2a_reg;
    buck_two_target_b = t2b_reg;
    buck_two_ramp_rate = rr2_reg;
    buck_function = bfunc_reg;
    linreg_one_voltage = lv1_reg;
    linreg_two_voltage = lv2_reg;
  end
endmodule : pmic_control_register_bank
`default_nettype wire

// file: hw/serial_line_events.sv
// Edge, start and stop detection on the two-wire serial lines
`timescale 1ns/1ps
`default_nettype none
module serial_line_events (
  input wire logic mclk,
  input wire logic sys_rst,
  input wire logic scl_in,
  input wire logic sda_in,
  output logic scl_rise,
  output logic scl_fall,
  output logic start_seen,
  output logic stop_seen
);
  logic scl_reg;
  logic sda_reg;
  logic scl_next;
  logic sda_next;

  always_comb begin
    scl_next = scl_in;
    sda_next = sda_in;
  end

  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      scl_reg <= 1'h1;
      sda_reg <= 1'h1;
    end else begin
      scl_reg <= scl_next;
      sda_reg <= sda_next;
    end
  end

  // Data moving while the clock stays high marks start or stop
  always_comb begin
    scl_rise = scl_in & ~scl_reg;
    scl_fall = ~scl_in & scl_reg;
    start_seen = scl_in & scl_reg & sda_reg & ~sda_in;
    stop_seen = scl_in & scl_reg & ~sda_reg & sda_in;
  end
endmodule : serial_line_events
`default_nettype wire

// file: include/pmic_regs_pkg.sv
// Register map, constants and states of the control bank
package pmic_regs_pkg;
  // Register offsets
  localparam logic [7:0] ADDR_THERMAL_FLAG_STATUS = 8'h02;
  localparam logic [7:0] ADDR_SYSTEM_CONTROL_ONE = 8'h07;
  localparam logic [7:0] ADDR_REGULATOR_ENABLE = 8'h10;
  localparam logic [7:0] ADDR_REGULATOR_VALID_STATUS = 8'h11;
  localparam logic [7:0] ADDR_VOLTAGE_CHANGE_CONTROL = 8'h20;
  localparam logic [7:0] ADDR_BUCK_ONE_TARGET_A = 8'h23;
  localparam logic [7:0] ADDR_BUCK_ONE_TARGET_B = 8'h24;
  localparam logic [7:0] ADDR_BUCK_ONE_RAMP_RATE = 8'h25;
  localparam logic [7:0] ADDR_BUCK_TWO_TARGET_A = 8'h29;
  localparam logic [7:0] ADDR_BUCK_TWO_TARGET_B = 8'h2A;
  localparam logic [7:0] ADDR_BUCK_TWO_RAMP_RATE = 8'h2B;
  localparam logic [7:0] ADDR_BUCK_FUNCTION = 8'h38;
  localparam logic [7:0] ADDR_LINREG_ONE_VOLTAGE = 8'h39;
  localparam logic [7:0] ADDR_LINREG_TWO_VOLTAGE = 8'h3A;

  // Field positions
  localparam int THERMAL_FLAG_BIT = 1;
  localparam int DELAY_PRESET_LSB = 4;
  localparam int SCR_RESERVED_ONE_BIT = 3;
  localparam int BUCK_TWO_PWM_BIT = 2;
  localparam int BUCK_ONE_PWM_BIT = 1;
  localparam int EXT_CLOCK_BIT = 0;
  localparam int LINREG_TWO_ON_BIT = 6;
  localparam int ENABLE_RESERVED_ONE_BIT = 5;
  localparam int LINREG_ONE_ON_BIT = 4;
  localparam int BUCK_TWO_ON_BIT = 2;
  localparam int BUCK_ONE_ON_BIT = 0;
  localparam int ALL_BUCKS_VALID_BIT = 7;
  localparam int ALL_LINREGS_VALID_BIT = 6;
  localparam int LINREG_TWO_VALID_BIT = 5;
  localparam int LINREG_ONE_VALID_BIT = 4;
  localparam int BUCK_TWO_VALID_BIT = 2;
  localparam int BUCK_ONE_VALID_BIT = 0;
  localparam int BUCK_TWO_SELECT_BIT = 5;
  localparam int BUCK_TWO_GO_BIT = 4;
  localparam int BUCK_ONE_SELECT_BIT = 1;
  localparam int BUCK_ONE_GO_BIT = 0;

  // Reset values
  localparam logic RST_EXT_CLOCK = 1'h0;
  localparam logic RST_REGULATOR_ON = 1'h1;
  localparam logic RST_VCC_BIT = 1'h0;
  localparam logic [3:0] RST_RAMP_RATE = 4'h8;
  localparam logic [2:0] RAMP_RESERVED_VALUE = 3'h2;
  localparam logic RST_STATUS_BIT = 1'h0;

  // Serial protocol
  localparam logic [3:0] BITS_PER_BYTE = 4'h8;
  localparam logic [6:0] DEFAULT_DEVICE_ADDRESS = 7'h60;

  // Power-on delays in 0.5 ms units, {buck1, buck2, linreg1, linreg2} per preset code
  localparam int DELAY_UNIT_US = 500;
  localparam logic [7:0][19:0] DELAY_TABLE = '{
    {5'h04, 5'h06, 5'h0C, 5'h16},
    {5'h06, 5'h04, 5'h02, 5'h03},
    {5'h03, 5'h03, 5'h04, 5'h04},
    {5'h03, 5'h04, 5'h06, 5'h0C},
    {5'h03, 5'h04, 5'h02, 5'h02},
    {5'h03, 5'h04, 5'h06, 5'h0C},
    {5'h02, 5'h03, 5'h04, 5'h04},
    {5'h02, 5'h02, 5'h02, 5'h02}
  };

  typedef enum logic [8:0] {
    ST_IDLE = 9'h001,
    ST_ADDR = 9'h002,
    ST_ADDR_ACK = 9'h004,
    ST_REG = 9'h008,
    ST_REG_ACK = 9'h010,
    ST_WDATA = 9'h020,
    ST_WDATA_ACK = 9'h040,
    ST_RDATA = 9'h080,
    ST_RDATA_ACK = 9'h100
  } link_state_t;
endpackage : pmic_regs_pkg

// file: tb/bank_chk.sv
// Concurrent checks for the control bank
`timescale 1ns/1ps
`default_nettype none
module bank_chk (
  input wire logic mclk,
  input wire logic sys_rst,
  input wire logic scl_in,
  input wire logic sda_in,
  input wire logic sda_out,
  input wire logic sda_oe_n,
  input wire logic [2:0] power_on_delay_preset,
  input wire logic [4:0] buck_one_delay,
  input wire logic [4:0] buck_two_delay,
  input wire logic [4:0] linreg_one_delay,
  input wire logic [4:0] linreg_two_delay,
  input wire logic external_clock_select,
  input wire logic buck_one_on,
  input wire logic buck_two_on,
  input wire logic linreg_one_on,
  input wire logic linreg_two_on,
  input wire logic buck_one_ramp_go,
  input wire logic buck_two_ramp_go,
  input wire logic [3:0] buck_one_ramp_rate,
  input wire logic [3:0] buck_two_ramp_rate,
  input wire logic [4:0] buck_one_target_a
);
  // Half-millisecond delays per preset code
  localparam logic [19:0] DLY [8] = '{
    {5'h02, 5'h02, 5'h02, 5'h02}, {5'h02, 5'h03, 5'h04, 5'h04},
    {5'h03, 5'h04, 5'h06, 5'h0C}, {5'h03, 5'h04, 5'h02, 5'h02},
    {5'h03, 5'h04, 5'h06, 5'h0C}, {5'h03, 5'h03, 5'h04, 5'h04},
    {5'h06, 5'h04, 5'h02, 5'h03}, {5'h04, 5'h06, 5'h0C, 5'h16}};
  default clocking @(posedge mclk); endclocking
  default disable iff (sys_rst);
  sequence start_cond;
    scl_in && $past(scl_in) && $past(sda_in) && !sda_in;
  endsequence
  sequence scl_low_two;
    !scl_in && !$past(scl_in);
  endsequence
  chk_delay_table: assert property ({buck_one_delay, buck_two_delay, linreg_one_delay,
    linreg_two_delay} == DLY[power_on_delay_preset])
    else $error("delay outputs differ from preset");
  chk_reset_values: assert property ($fell(sys_rst) |-> buck_one_on && buck_two_on
    && linreg_one_on && linreg_two_on && !buck_one_ramp_go && !buck_two_ramp_go)
    else $error("enables wrong after reset");
  chk_rate_reset: assert property ($fell(sys_rst) |-> buck_one_ramp_rate == 4'h8
    && buck_two_ramp_rate == 4'h8 && !external_clock_select && sda_oe_n)
    else $error("reset values wrong");
  chk_drive_low: assert property (sda_out == 1'b0)
    else $error("data line driven high");
  chk_oe_scl_low: assert property ($changed(sda_oe_n) && !$past(sys_rst) |-> scl_low_two)
    else $error("drive changed while clock high");
  chk_quiet_address: assert property (start_cond |=> sda_oe_n [*8])
    else $error("data pulled after start");
  chk_ack_holds: assert property ($fell(sda_oe_n) |-> !sda_oe_n [*4])
    else $error("pull too short");
  chk_write_ack: assert property ($changed({buck_one_on, linreg_two_on, buck_two_ramp_go,
    power_on_delay_preset, buck_one_target_a}) && !$past(sys_rst) |-> $fell(sda_oe_n))
    else $error("register changed without ack");
endmodule : bank_chk
bind pmic_control_register_bank bank_chk i_bank_chk (.*);
`default_nettype wire

// file: tb/bus_host.sv
// Two-wire serial host model
`timescale 1ns/1ps
`default_nettype none
module bus_host (
  input wire logic mclk,
  input wire logic sda_in,
  output var logic scl,
  output var logic sda_low
);
  initial begin
    scl = 1'b1;
    sda_low = 1'b0;
  end
  task automatic wt(input int n);
    repeat (n) @(posedge mclk);
  endtask : wt
  // Data changes only while clock is low
  task automatic put(input logic b);
    scl <= 1'b0;
    wt(2);
    sda_low <= !b;
    wt(4);
    scl <= 1'b1;
    wt(6);
  endtask : put
  task automatic get(output logic b);
    scl <= 1'b0;
    sda_low <= 1'b0;
    wt(6);
    scl <= 1'b1;
    wt(3);
    b = sda_in;
    wt(3);
  endtask : get
  task automatic start();
    scl <= 1'b0;
    wt(3);
    sda_low <= 1'b0;
    wt(3);
    scl <= 1'b1;
    wt(3);
    sda_low <= 1'b1;
    wt(3);
  endtask : start
  task automatic stop();
    scl <= 1'b0;
    wt(3);
    sda_low <= 1'b1;
    wt(3);
    scl <= 1'b1;
    wt(3);
    sda_low <= 1'b0;
    wt(3);
  endtask : stop
  task automatic send(input logic [7:0] d, output logic ack);
    logic b;
    for (int i = 7; i >= 0; i--) put(d[i]);
    get(b);
    ack = !b;
  endtask : send
  task automatic recv(input logic more, output logic [7:0] d);
    for (int i = 7; i >= 0; i--) get(d[i]);
    put(!more);
  endtask : recv
endmodule : bus_host
`default_nettype wire

// file: tb/tb.sv
// Self-checking bench for the control bank
`timescale 1ns/1ps
`default_nettype none
module tb;
  import pmic_regs_pkg::*;
  logic mclk = 1'b0;
  logic sys_rst = 1'b1;
  logic over_temperature = 1'b0;
  logic buck_one_valid = 1'b0, buck_two_valid = 1'b0;
  logic linreg_one_valid = 1'b0, linreg_two_valid = 1'b0;
  logic scl_in, sda_low, sda_out, sda_oe_n, buck_one_forced_pwm, buck_two_forced_pwm;
  logic external_clock_select, buck_one_on, buck_two_on, linreg_one_on, linreg_two_on;
  logic buck_one_target_select, buck_two_target_select, buck_one_ramp_go, buck_two_ramp_go;
  logic [2:0] power_on_delay_preset;
  logic [4:0] buck_one_delay, buck_two_delay, linreg_one_delay, linreg_two_delay;
  logic [4:0] buck_one_target_a, buck_one_target_b, buck_two_target_a, buck_two_target_b;
  logic [3:0] buck_one_ramp_rate, buck_two_ramp_rate;
  logic [7:0] buck_function, linreg_one_voltage, linreg_two_voltage;
  wire logic sda_in;
  int bad_count = 0;
  int checks_done = 0;
  logic [7:0] dev_w = {DEFAULT_DEVICE_ADDRESS, 1'b0};
  // Open-drain wire with pull-up
  assign sda_in = !(sda_low || (!sda_oe_n && !sda_out));
  pmic_control_register_bank i_pmic_control_register_bank (.*);
  bus_host i_bus_host (.mclk(mclk), .sda_in(sda_in), .scl(scl_in), .sda_low(sda_low));
  always #5 mclk = ~mclk;
  task automatic check(input logic [7:0] seen, exp);
    checks_done++;
    if (seen !== exp) begin
      bad_count++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check
  task automatic summarize();
    $display("checks_done=%0d bad_count=%0d", checks_done, bad_count);
    if (bad_count == 0 && checks_done > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask : summarize
  task automatic wr(input logic [7:0] a, d);
    logic [2:0] k;
    i_bus_host.start();
    i_bus_host.send(dev_w, k[0]);
    i_bus_host.send(a, k[1]);
    i_bus_host.send(d, k[2]);
    i_bus_host.stop();
    check({5'h00, k}, 8'h07);
  endtask : wr
  task automatic rd(input logic [7:0] a, input logic more, output logic [7:0] d);
    logic [2:0] k;
    i_bus_host.start();
    i_bus_host.send(dev_w, k[0]);
    i_bus_host.send(a, k[1]);
    i_bus_host.start();
    i_bus_host.send(dev_w | 8'h01, k[2]);
    i_bus_host.recv(more, d);
    check({5'h00, k}, 8'h07);
  endtask : rd
  task automatic rc(input logic [7:0] a, exp);
    logic [7:0] d;
    rd(a, 1'b0, d);
    i_bus_host.stop();
    check(d, exp);
  endtask : rc
  task automatic t_reset_vals();
    logic [15:0] t [15] = '{16'h0200, 16'h0708, 16'h1075, 16'h1100, 16'h2000, 16'h2300,
      16'h2400, 16'h2528, 16'h2900, 16'h2A00, 16'h2B28, 16'h3800, 16'h3900, 16'h3A00, 16'h3000};
    for (int i = 0; i < 15; i++) rc(t[i][15:8], t[i][7:0]);
  endtask : t_reset_vals
  task automatic t_rw();
    logic [23:0] t [15] = '{24'h07FF7F, 24'h100020, 24'h20FF33, 24'h23FF1F, 24'h240A0A,
      24'h25FF2F, 24'h291515, 24'h2AFF1F, 24'h2B0323, 24'h38A5A5, 24'h395A5A, 24'h3AC3C3,
      24'h30FF00, 24'h02FF00, 24'h11FF00};
    for (int i = 0; i < 15; i++) begin
      wr(t[i][23:16], t[i][15:8]);
      rc(t[i][23:16], t[i][7:0]);
    end
    check({1'b0, power_on_delay_preset, 1'b0, buck_two_forced_pwm, buck_one_forced_pwm,
      external_clock_select}, 8'h77);
    check({1'b0, linreg_two_on, 1'b0, linreg_one_on, 1'b0, buck_two_on, 1'b0, buck_one_on},
      8'h00);
    check({2'h0, buck_two_target_select, buck_two_ramp_go, 2'h0, buck_one_target_select,
      buck_one_ramp_go}, 8'h33);
    check({buck_one_ramp_rate, buck_two_ramp_rate}, 8'hF3);
    check({3'h0, buck_two_target_a}, 8'h15);
    check(buck_function, 8'hA5);
    check(linreg_one_voltage ^ linreg_two_voltage, 8'h99);
    check({buck_one_target_b[3:0], buck_two_target_b[3:0]}, 8'hAF);
    wr(ADDR_REGULATOR_ENABLE, 8'h05);
    check({1'b0, linreg_two_on, 1'b0, linreg_one_on, 1'b0, buck_two_on, 1'b0, buck_one_on},
      8'h05);
  endtask : t_rw
  task automatic t_presets();
    for (int c = 0; c < 8; c++) begin
      wr(ADDR_SYSTEM_CONTROL_ONE, {1'b0, c[2:0], 4'h8});
      check({5'h00, power_on_delay_preset}, c[7:0]);
      check({6'h00, buck_two_forced_pwm, buck_one_forced_pwm}, 8'h00);
    end
  endtask : t_presets
  task automatic t_status();
    for (int i = 0; i < 16; i++) begin
      {linreg_two_valid, linreg_one_valid, buck_two_valid, buck_one_valid} <= i[3:0];
      over_temperature <= i[1] ^ i[2];
      i_bus_host.wt(3);
      rc(ADDR_REGULATOR_VALID_STATUS, {i[0] & i[1], i[2] & i[3], i[3], i[2], 1'b0, i[1], 1'b0,
        i[0]});
      rc(ADDR_THERMAL_FLAG_STATUS, {6'h00, i[1] ^ i[2], 1'b0});
    end
  endtask : t_status
  task automatic t_abort();
    logic k;
    i_bus_host.start();
    i_bus_host.send({7'h61, 1'b0}, k);
    check({7'h00, k}, 8'h00);
    i_bus_host.send(ADDR_LINREG_ONE_VOLTAGE, k);
    i_bus_host.send(8'h00, k);
    i_bus_host.stop();
    i_bus_host.start();
    i_bus_host.send(dev_w, k);
    i_bus_host.send(ADDR_LINREG_ONE_VOLTAGE, k);
    for (int i = 0; i < 4; i++) i_bus_host.put(1'b0);
    i_bus_host.stop();
    rc(ADDR_LINREG_ONE_VOLTAGE, 8'h5A);
  endtask : t_abort
  task automatic t_no_incr();
    logic k;
    logic [7:0] d;
    i_bus_host.start();
    i_bus_host.send(dev_w, k);
    i_bus_host.send(ADDR_LINREG_ONE_VOLTAGE, k);
    i_bus_host.send(8'h11, k);
    i_bus_host.send(8'h22, k);
    i_bus_host.stop();
    rc(ADDR_LINREG_TWO_VOLTAGE, 8'hC3);
    rd(ADDR_LINREG_ONE_VOLTAGE, 1'b1, d);
    check(d, 8'h22);
    i_bus_host.recv(1'b0, d);
    i_bus_host.stop();
    check(d, 8'h22);
  endtask : t_no_incr
  task automatic t_midrun();
    sys_rst <= 1'b1;
    i_bus_host.wt(8);
    sys_rst <= 1'b0;
    i_bus_host.wt(1);
    rc(ADDR_REGULATOR_ENABLE, 8'h75);
    rc(ADDR_SYSTEM_CONTROL_ONE, 8'h08);
  endtask : t_midrun
  initial begin
    repeat (80000) @(posedge mclk);
    bad_count++;
    summarize();
  end
  initial begin
    repeat (8) @(posedge mclk);
    sys_rst <= 1'b0;
    @(posedge mclk);
    t_reset_vals();
    t_rw();
    t_presets();
    t_status();
    t_abort();
    t_no_incr();
    t_midrun();
    summarize();
  end
endmodule : tb
`default_nettype wire
